// ---- hw/rcs_pkg.sv ----
// Package with constants and types for the reset and calibration sequencer
package rcs_pkg;
  localparam logic [1:0] RCS_SEL_SPI = 2'h0;
  localparam logic [1:0] RCS_SEL_I2C = 2'h1;
  localparam logic [1:0] RCS_SEL_PIN = 2'h2;
  localparam logic [1:0] RCS_SEL_RSV = 2'h3;
  localparam int RCS_TIMER_NS = 1000;
  localparam int RCS_CLK_NS = 5;
  localparam int RCS_TIMER_CYC = (RCS_TIMER_NS + RCS_CLK_NS - 1) / RCS_CLK_NS;
  localparam int RCS_CAL_CYC = 64;
  localparam int RCS_CFG_W = 8;
  localparam logic [7:0] RCS_CFG_DEFAULT = 8'h00;
  typedef enum logic [4:0] {
    RCS_ST_RESET = 5'b0_0001,
    RCS_ST_LOAD = 5'b0_0010,
    RCS_ST_STAB = 5'b0_0100,
    RCS_ST_CAL = 5'b0_1000,
    RCS_ST_RUN = 5'b1_0000
  } rcs_state_type;
endpackage : rcs_pkg

// ---- hw/rcs_link_if.sv ----
// Interface joining the host controller and the sequencer
`timescale 1ns/1ps
`default_nettype none
interface rcs_link_if;
  logic power_down_pin;
  logic reset_pin_n;
  logic output_sync_pin;
  logic [1:0] mode_sel;
  logic soft_reset_bit;
  logic cfg_write;
  logic [7:0] cfg_data;
  logic serial_busy;
  modport device (
    input power_down_pin, reset_pin_n, output_sync_pin, mode_sel,
    input soft_reset_bit, cfg_write, cfg_data, serial_busy
  );
  modport host (
    output power_down_pin, reset_pin_n, output_sync_pin, mode_sel,
    output soft_reset_bit, cfg_write, cfg_data, serial_busy
  );
endinterface : rcs_link_if
`default_nettype wire

// ---- hw/rcs_device.sv ----
// Device end: reset, default reload, stabilisation and calibration sequence
`timescale 1ns/1ps
`default_nettype none
module rcs_device #(
  parameter int TIMER_CYC = rcs_pkg::RCS_TIMER_CYC,
  parameter int CAL_CYC = rcs_pkg::RCS_CAL_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  rcs_link_if.device link,
  input wire logic supply_ok,
  input wire logic [7:0] cfg_pins,
  output logic outputs_enable,
  output logic cal_active,
  output logic normal_mode,
  output logic [7:0] active_cfg,
  output logic mode_reserved
);
  import rcs_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  rcs_state_type state_reg, state_next;
  logic [15:0] count_reg, count_next;
  logic [7:0] cfg_reg, cfg_next;
  logic soft_prev_reg, soft_prev_next;
  logic oe_reg, oe_next;
  logic cal_reg, cal_next;
  logic norm_reg, norm_next;
  logic [7:0] act_reg, act_next;
  logic rsv_reg, rsv_next;
  logic pin_mode;
  logic hard_reset;
  logic soft_fall;
  // In pin mode the configuration comes from cfg_pins and serial writes are ignored
  assign pin_mode = (link.mode_sel == RCS_SEL_PIN);
  assign hard_reset = !link.power_down_pin || !link.reset_pin_n;
  assign soft_fall = soft_prev_reg && !link.soft_reset_bit;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    cfg_next = cfg_reg;
    soft_prev_next = link.soft_reset_bit;
    if (hard_reset) begin
      state_next = RCS_ST_RESET;
      count_next = 16'h0000;
    end else begin
      case (state_reg)
        RCS_ST_RESET: begin
          state_next = RCS_ST_LOAD;
        end
        RCS_ST_LOAD: begin
          cfg_next = RCS_CFG_DEFAULT;
          count_next = 16'h0000;
          state_next = RCS_ST_STAB;
        end
        RCS_ST_STAB: begin
          // Timer stops at TIMER_CYC and holds while supplies settle; both must agree
          if (count_reg < 16'(TIMER_CYC)) begin
            count_next = count_reg + 16'h0001;
          end else if (supply_ok) begin
            count_next = 16'h0000;
            state_next = RCS_ST_CAL;
          end
        end
        RCS_ST_CAL: begin
          if (count_reg < 16'(CAL_CYC - 1)) begin
            count_next = count_reg + 16'h0001;
          end else begin
            state_next = RCS_ST_RUN;
          end
        end
        RCS_ST_RUN: begin
          if (link.cfg_write && !pin_mode) begin
            cfg_next = link.cfg_data;
          end
        end
        default: begin
          state_next = RCS_ST_RESET;
        end
      endcase
      // Soft reset keeps the register contents and skips the reload
      if (soft_fall && state_reg != RCS_ST_RESET && state_reg != RCS_ST_LOAD) begin
        state_next = RCS_ST_STAB;
        count_next = 16'h0000;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Outputs stay off while the soft bit is high, so a load can finish first
    oe_next = (state_next == RCS_ST_RUN) && !link.soft_reset_bit
              && link.output_sync_pin && (link.mode_sel != RCS_SEL_RSV);
    cal_next = (state_next == RCS_ST_CAL);
    norm_next = !hard_reset && (state_next == RCS_ST_RUN);
    act_next = pin_mode ? cfg_pins : cfg_next;
    rsv_next = (link.mode_sel == RCS_SEL_RSV);
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= RCS_ST_RESET;
      count_reg <= 16'h0000;
      cfg_reg <= RCS_CFG_DEFAULT;
      soft_prev_reg <= 1'b0;
      oe_reg <= 1'b0;
      cal_reg <= 1'b0;
      norm_reg <= 1'b0;
      act_reg <= 8'h00;
      rsv_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      count_reg <= count_next;
      cfg_reg <= cfg_next;
      soft_prev_reg <= soft_prev_next;
      oe_reg <= oe_next;
      cal_reg <= cal_next;
      norm_reg <= norm_next;
      act_reg <= act_next;
      rsv_reg <= rsv_next;
    end
  end
  assign outputs_enable = oe_reg;
  assign cal_active = cal_reg;
  assign normal_mode = norm_reg;
  assign active_cfg = act_reg;
  assign mode_reserved = rsv_reg;
endmodule : rcs_device
`default_nettype wire

// ---- hw/rcs_host.sv ----
// Host end: drives reset pins, mode select, soft reset and serial writes
`timescale 1ns/1ps
`default_nettype none
module rcs_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  rcs_link_if.host link,
  input wire logic [1:0] mode_req,
  input wire logic mode_change,
  input wire logic write_req,
  input wire logic [7:0] write_data,
  input wire logic use_soft,
  output logic busy
);
  import rcs_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    RCS_H_IDLE = 5'b0_0001,
    RCS_H_PDN = 5'b0_0010,
    RCS_H_WRITE = 5'b0_0100,
    RCS_H_POST = 5'b0_1000,
    RCS_H_REL = 5'b1_0000
  } rcs_hstate_type;
  rcs_hstate_type st_reg, st_next;
  logic pdn_reg, pdn_next;
  logic rstn_reg, rstn_next;
  logic sync_reg, sync_next;
  logic [1:0] sel_reg, sel_next;
  logic soft_reg, soft_next;
  logic wr_reg, wr_next;
  logic [7:0] data_reg, data_next;
  logic busy_reg, busy_next;
  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    pdn_next = pdn_reg;
    rstn_next = rstn_reg;
    sync_next = sync_reg;
    sel_next = sel_reg;
    soft_next = soft_reg;
    wr_next = 1'b0;
    data_next = data_reg;
    case (st_reg)
      RCS_H_IDLE: begin
        if (mode_change) begin
          sel_next = mode_req;
          pdn_next = 1'b0;
          st_next = RCS_H_PDN;
        end else if (write_req) begin
          // Reset stays high over the serial write; outputs muted instead
          if (use_soft) begin
            soft_next = 1'b1;
          end else begin
            sync_next = 1'b0;
          end
          data_next = write_data;
          st_next = RCS_H_WRITE;
        end
      end
      RCS_H_PDN: begin
        pdn_next = 1'b1;
        st_next = RCS_H_IDLE;
      end
      RCS_H_WRITE: begin
        wr_next = 1'b1;
        st_next = RCS_H_POST;
      end
      RCS_H_POST: begin
        if (soft_reg) begin
          soft_next = 1'b0;
          st_next = RCS_H_IDLE;
        end else begin
          rstn_next = 1'b0;
          st_next = RCS_H_REL;
        end
      end
      RCS_H_REL: begin
        rstn_next = 1'b1;
        sync_next = 1'b1;
        st_next = RCS_H_IDLE;
      end
      default: begin
        st_next = RCS_H_IDLE;
      end
    endcase
    // Reset pin rises once the host is idle, so a held-off start ends cleanly
    if (st_reg == RCS_H_IDLE && !busy_reg && !rstn_reg) begin
      rstn_next = 1'b1;
    end
    busy_next = (st_next != RCS_H_IDLE);
  end
  //////////////////////////////////////////////////////////////////////////
  // Reset pin is low while rst is high, so outputs stay off until released
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= RCS_H_IDLE;
      pdn_reg <= 1'b1;
      rstn_reg <= 1'b0;
      sync_reg <= 1'b1;
      sel_reg <= RCS_SEL_SPI;
      soft_reg <= 1'b0;
      wr_reg <= 1'b0;
      data_reg <= 8'h00;
      busy_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      pdn_reg <= pdn_next;
      rstn_reg <= rstn_next;
      sync_reg <= sync_next;
      sel_reg <= sel_next;
      soft_reg <= soft_next;
      wr_reg <= wr_next;
      data_reg <= data_next;
      busy_reg <= busy_next;
    end
  end
  assign link.power_down_pin = pdn_reg;
  assign link.reset_pin_n = rstn_reg;
  assign link.output_sync_pin = sync_reg;
  assign link.mode_sel = sel_reg;
  assign link.soft_reset_bit = soft_reg;
  assign link.cfg_write = wr_reg;
  assign link.cfg_data = data_reg;
  assign link.serial_busy = wr_reg;
  assign busy = busy_reg;
endmodule : rcs_host
`default_nettype wire

// ---- tb/rcs_checker.sv ----
// Checker of the link pins and device outputs of the sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_checker import rcs_pkg::*; #(
  parameter int TIMER_CYC = RCS_TIMER_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_down_pin,
  input wire logic reset_pin_n,
  input wire logic soft_reset_bit,
  input wire logic [1:0] mode_sel,
  input wire logic supply_ok,
  input wire logic [7:0] cfg_pins,
  input wire logic outputs_enable,
  input wire logic cal_active,
  input wire logic normal_mode,
  input wire logic [7:0] active_cfg,
  input wire logic mode_reserved
);
  // Cycles since both pins high; soft restarts only make it larger, so the bound stays safe
  logic [15:0] up_reg;
  logic [15:0] up_next;
  always_comb begin
    up_next = up_reg + 16'h0001;
    if (!power_down_pin || !reset_pin_n) up_next = 16'h0000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_reg <= 16'h0000;
    else up_reg <= up_next;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  pins_low_a: assert property ((!power_down_pin || !reset_pin_n) |=> !normal_mode && !outputs_enable)
    else $error("Device active with a pin low");
  normal_pins_a: assert property (normal_mode |-> $past(power_down_pin && reset_pin_n))
    else $error("Normal mode without both pins high");
  cal_off_a: assert property (cal_active |-> !outputs_enable)
    else $error("Outputs on during calibration");
  cal_len_a: assert property ($rose(cal_active) |-> cal_active[*3] ##[1:2] !cal_active)
    else $error("Calibration length wrong");
  stab_time_a: assert property ($rose(cal_active) |-> up_reg >= TIMER_CYC && $past(supply_ok))
    else $error("Calibration before timer or supplies");
  soft_mute_a: assert property ($fell(soft_reset_bit) |-> !outputs_enable[*8])
    else $error("Outputs on right after soft reset");
  soft_keep_a: assert property ($fell(soft_reset_bit) |-> ##1 $stable(active_cfg)[*4])
    else $error("Soft reset changed configuration");
  pin_cfg_a: assert property ((mode_sel == RCS_SEL_PIN && $past(mode_sel) == RCS_SEL_PIN
    && $stable(cfg_pins)) |-> active_cfg == cfg_pins)
    else $error("Pin mode config not from pins");
  rsv_flag_a: assert property (mode_reserved == ($past(mode_sel) == RCS_SEL_RSV))
    else $error("Reserved flag wrong");
  pin_reload_a: assert property (($rose(reset_pin_n) && mode_sel != RCS_SEL_PIN)
    |-> ##[1:3] active_cfg == RCS_CFG_DEFAULT)
    else $error("Defaults not reloaded");
  cover property ($rose(outputs_enable));
  cover property ($fell(soft_reset_bit));
  cover property (mode_reserved);
endmodule : rcs_checker
`default_nettype wire

// ---- tb/reset_calibration_sequencer_test.sv ----
// Testbench joining host and device ends of the sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_calibration_sequencer_test;
  import rcs_pkg::*;
  localparam int TIMER = 8;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic supply_ok = 1'h0;
  logic [7:0] cfg_pins = 8'h00;
  logic [1:0] mode_req = 2'h0;
  logic mode_change = 1'h0;
  logic write_req = 1'h0;
  logic [7:0] write_data = 8'h00;
  logic use_soft = 1'h0;
  logic busy, outputs_enable, cal_active, normal_mode, mode_reserved;
  logic [7:0] active_cfg;
  int failures = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  rcs_link_if link();
  rcs_host i_rcs_host (.clk(clk), .rst(rst), .ce(1'h1), .link(link.host), .mode_req(mode_req),
    .mode_change(mode_change), .write_req(write_req), .write_data(write_data),
    .use_soft(use_soft), .busy(busy));
  // Short calibration keeps the run brief; checks use the same figures
  rcs_device #(.TIMER_CYC(TIMER), .CAL_CYC(4)) i_rcs_device (.clk(clk), .rst(rst), .ce(1'h1),
    .link(link.device), .supply_ok(supply_ok), .cfg_pins(cfg_pins),
    .outputs_enable(outputs_enable), .cal_active(cal_active), .normal_mode(normal_mode),
    .active_cfg(active_cfg), .mode_reserved(mode_reserved));
  rcs_checker #(.TIMER_CYC(TIMER)) i_rcs_checker (.clk(clk), .rst(rst),
    .power_down_pin(link.power_down_pin), .reset_pin_n(link.reset_pin_n),
    .soft_reset_bit(link.soft_reset_bit), .mode_sel(link.mode_sel), .supply_ok(supply_ok),
    .cfg_pins(cfg_pins), .outputs_enable(outputs_enable), .cal_active(cal_active),
    .normal_mode(normal_mode), .active_cfg(active_cfg), .mode_reserved(mode_reserved));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (outputs_enable !== lvl && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      failures++;
      $display("MISMATCH at %0t: wait ran out", $time);
      stop_test();
    end
  endtask : wait_oe
  // One host request, then wait for the host to go idle again
  task automatic req(input logic mc, input logic [1:0] m, input logic [7:0] d, input logic s);
    int n;
    mode_req = m;
    write_data = d;
    use_soft = s;
    mode_change = mc;
    write_req = !mc;
    @(negedge clk);
    mode_change = 1'h0;
    write_req = 1'h0;
    n = 0;
    while (busy !== 1'h0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, busy}, 8'h00);
  endtask : req
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    repeat (TIMER + 20) @(negedge clk);
    chk({7'h00, outputs_enable}, 8'h00);
    supply_ok = 1'h1;
    wait_oe(1'h1);
    chk(active_cfg, RCS_CFG_DEFAULT);
    chk({7'h00, normal_mode}, 8'h01);
    chk({7'h00, cal_active}, 8'h00);
    $display("power-up test done");
  endtask : t_power
  task automatic t_soft();
    req(1'h0, RCS_SEL_SPI, 8'h5A, 1'h1);
    chk({7'h00, outputs_enable}, 8'h00);
    wait_oe(1'h1);
    chk(active_cfg, 8'h5A);
    $display("soft write test done");
  endtask : t_soft
  task automatic t_sync();
    req(1'h0, RCS_SEL_SPI, 8'h3C, 1'h0);
    chk({7'h00, outputs_enable}, 8'h00);
    wait_oe(1'h1);
    chk(active_cfg, RCS_CFG_DEFAULT);
    $display("sync write test done");
  endtask : t_sync
  task automatic t_pin();
    cfg_pins = 8'hA5;
    req(1'h1, RCS_SEL_PIN, 8'h00, 1'h0);
    chk({7'h00, outputs_enable}, 8'h00);
    wait_oe(1'h1);
    chk(active_cfg, 8'hA5);
    cfg_pins = 8'h0F;
    repeat (2) @(negedge clk);
    chk(active_cfg, 8'h0F);
    req(1'h0, RCS_SEL_PIN, 8'h77, 1'h1);
    wait_oe(1'h1);
    chk(active_cfg, 8'h0F);
    $display("pin mode test done");
  endtask : t_pin
  task automatic t_rsv();
    req(1'h1, RCS_SEL_RSV, 8'h00, 1'h0);
    repeat (TIMER + 20) @(negedge clk);
    chk({7'h00, mode_reserved}, 8'h01);
    chk({7'h00, outputs_enable}, 8'h00);
    req(1'h1, RCS_SEL_I2C, 8'h00, 1'h0);
    wait_oe(1'h1);
    chk({7'h00, mode_reserved}, 8'h00);
    chk(active_cfg, RCS_CFG_DEFAULT);
    $display("mode select test done");
  endtask : t_rsv
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    repeat (2) @(negedge clk);
    t_power();
    t_soft();
    t_sync();
    t_pin();
    t_rsv();
    stop_test();
  end
endmodule : reset_calibration_sequencer_test
`default_nettype wire
